// *** inc/pipe_req_pkg.sv ***
// Shared constants for the pipelined read request link
package pipe_req_pkg;
  localparam int ADDR_W = 32;
  localparam int CMD_W = 4;
  localparam int LEN_W = 3;
  localparam int STAT_W = 3;
  localparam int LEN_LSB = 0;
  localparam int LEN_MSB = 2;
  localparam int ADDR_LSB = 3;
  localparam int ADDR_MSB = 31;
  localparam logic [STAT_W-1:0] STAT_START = 3'h7;
  localparam logic [STAT_W-1:0] STAT_IDLE = 3'h0;
  // Read command codes, active-high form; the pins carry the inverse
  localparam logic [CMD_W-1:0] CMD_READ = 4'h0;
  localparam logic [CMD_W-1:0] CMD_READ_HI = 4'h4;
  // Length field counts quadwords minus one
  localparam int QWORD_BYTES = 8;
  localparam int SPLIT_LIMIT_BYTES = 64;
  localparam int CHUNK_BYTES = 32;
  localparam logic [LEN_W-1:0] LEN_CHUNK = 3'(CHUNK_BYTES / QWORD_BYTES - 1);
  localparam int QUEUE_DEPTH = 4;
  localparam int CNT_W = 3;
  localparam int START_DELAY_MAX = 2;
  localparam int BYTES_W = 12;
  localparam logic [BYTES_W-1:0] CHUNK_BYTES_V = 12'h020;
  localparam logic [BYTES_W-1:0] LIMIT_BYTES_V = 12'h040;
  localparam logic [BYTES_W-1:0] QWORD_BYTES_V = 12'h008;
endpackage

// *** inc/pipe_req_if.sv ***
// Link between the read requester and the bridge arbiter
`timescale 1ns/10ps
`default_nettype none
interface pipe_req_if;
  import pipe_req_pkg::*;
  logic bus_request_n;
  logic bus_grant_n;
  logic [STAT_W-1:0] grant_status_code;
  logic request_enqueue_strobe_n;
  logic frame_n;
  logic [ADDR_W-1:0] addr_data_bus;
  logic [CMD_W-1:0] command_byte_enable_n;
  logic addr_data_oe;
  modport requester (
    output bus_request_n,
    input bus_grant_n,
    input grant_status_code,
    output request_enqueue_strobe_n,
    output frame_n,
    output addr_data_bus,
    output command_byte_enable_n,
    output addr_data_oe
  );
  modport arbiter (
    input bus_request_n,
    output bus_grant_n,
    output grant_status_code,
    input request_enqueue_strobe_n,
    input frame_n,
    input addr_data_bus,
    input command_byte_enable_n,
    input addr_data_oe
  );
endinterface
`default_nettype wire

// *** rtl/pipe_read_requester.sv ***
// Device end: queues pipelined system-memory read requests onto the link
// Notes on behaviour
// R01 - Only normal and high-priority reads issued
// R02 - Plain PCI cycles may fill gaps
// R03 - Grant status START means request permission
// R04 - At most four outstanding read requests
// R05 - Reads over 64 bytes split into 32s
// R06 - Idle bus: requests on consecutive clocks
// R07 - Break into replies via request/grant
// R08 - High priority when render nears stall
// R09 - Assert bus request before driving bus
// R10 - Arbiter grants with grant low, START
// R11 - Begin within two clocks of START
// R12 - Idle bus: begin next clock or after
// R13 - One request enqueued per strobe clock
// R14 - Address 31:3, length 2:0, command lines
// R15 - Last request: strobe with request released
// R16 - Request held with strobe: more follow
// R17 - Release strobe after request sampled high
// R18 - Enqueue until empty or slots full
// R19 - Arbiter drops grant after strobe or frame
// R20 - Requests target system memory only
// R21 - Length and command codes per standard
`timescale 1ns/10ps
`default_nettype none
module pipe_read_requester (
  input wire logic CLK_SYS_IN,
  input wire logic NRST_IN,
  pipe_req_if.requester LINK,
  input wire logic RD_VALID_IN,
  input wire logic [pipe_req_pkg::ADDR_W-1:0] RD_ADDR_IN,
  input wire logic [pipe_req_pkg::BYTES_W-1:0] RD_BYTES_IN,
  input wire logic STALL_NEAR_IN,
  input wire logic REPLY_DONE_IN,
  input wire logic [pipe_req_pkg::CNT_W-1:0] SLOTS_FREE_IN,
  output logic RD_READY_OUT,
  output logic [pipe_req_pkg::CNT_W-1:0] OUTSTANDING_OUT
);
  import pipe_req_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ = 2'b01,
    ST_ENQ = 2'b10,
    ST_END = 2'b11
  } state_t;

  state_t state_reg, state_next;
  logic busy_reg, busy_next;
  logic split_reg, split_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [BYTES_W-1:0] left_reg, left_next;
  logic hi_reg, hi_next;
  logic [CNT_W-1:0] outst_reg, outst_next;
  logic [CNT_W-1:0] sent_reg, sent_next;
  logic [CNT_W-1:0] slots_reg, slots_next;
  logic breq_n_reg, breq_n_next;
  logic strobe_n_reg, strobe_n_next;
  logic oe_reg, oe_next;
  logic [ADDR_W-1:0] ad_reg, ad_next;
  logic [CMD_W-1:0] cbe_n_reg, cbe_n_next;
  logic ready_reg, ready_next;
  logic [BYTES_W-1:0] piece;
  logic [LEN_W-1:0] piece_len;
  logic start_seen;
  logic last_piece;
  logic room_after;

  // Link shares the clock; a sync stage here would break the two-clock start limit
  assign start_seen = !LINK.bus_grant_n && (LINK.grant_status_code == STAT_START); // see R03 see R10

  always_comb
  begin
    // A job over the limit goes out wholly in fixed chunks, otherwise in one piece
    if (split_reg)
      piece = CHUNK_BYTES_V; // see R05
    else
      piece = left_reg;
    piece_len = LEN_W'((piece + QWORD_BYTES_V - 12'h001) / QWORD_BYTES_V - 12'h001); // see R21
    last_piece = (left_reg <= piece);
    room_after = (sent_reg + 3'h1 < slots_reg) && (outst_reg + 3'h1 < 3'(QUEUE_DEPTH));
  end

  always_comb
  begin
    state_next = state_reg;
    busy_next = busy_reg;
    split_next = split_reg;
    addr_next = addr_reg;
    left_next = left_reg;
    hi_next = hi_reg;
    outst_next = outst_reg;
    sent_next = sent_reg;
    slots_next = slots_reg;
    breq_n_next = breq_n_reg;
    strobe_n_next = 1'b1;
    oe_next = 1'b0;
    ad_next = ad_reg;
    cbe_n_next = cbe_n_reg;
    ready_next = 1'b0;
    if (REPLY_DONE_IN && outst_reg != 3'h0)
      outst_next = outst_reg - 3'h1;
    if (!busy_reg && RD_VALID_IN && !ready_reg && state_reg == ST_IDLE)
    begin
      busy_next = 1'b1;
      ready_next = 1'b1;
      addr_next = RD_ADDR_IN; // see R20
      left_next = RD_BYTES_IN;
      split_next = (RD_BYTES_IN > LIMIT_BYTES_V); // see R05
      hi_next = STALL_NEAR_IN; // see R08
    end
    case (state_reg)
      ST_IDLE:
      begin
        // Ask for the bus whenever a slot is free, also mid reply stream
        if (busy_reg && outst_reg < 3'(QUEUE_DEPTH) && SLOTS_FREE_IN != 3'h0) // see R04 see R07
        begin
          breq_n_next = 1'b0; // see R09
          state_next = ST_REQ;
        end
      end
      ST_REQ:
      begin
        if (start_seen)
        begin
          slots_next = SLOTS_FREE_IN;
          sent_next = 3'h0;
          state_next = ST_ENQ;
        end
      end
      ST_ENQ:
      begin
        // First strobe two clocks after START appears, the latest allowed
        strobe_n_next = 1'b0; // see R11 see R12 see R13 see R06
        oe_next = 1'b1;
        ad_next = {addr_reg[ADDR_MSB:ADDR_LSB], piece_len}; // see R14
        cbe_n_next = ~(hi_reg ? CMD_READ_HI : CMD_READ); // see R01
        outst_next = outst_next + 3'h1;
        sent_next = sent_reg + 3'h1;
        addr_next = addr_reg + ADDR_W'(piece);
        left_next = last_piece ? 12'h000 : left_reg - piece;
        if (last_piece || !room_after) // see R18
        begin
          breq_n_next = 1'b1; // see R15
          state_next = ST_END;
          if (last_piece)
            busy_next = 1'b0;
        end
        else
          breq_n_next = 1'b0; // see R16
      end
      ST_END:
      begin
        // Strobe and bus released the clock after the request goes high
        state_next = ST_IDLE; // see R17 see R02
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      state_reg <= ST_IDLE;
      busy_reg <= 1'b0;
      split_reg <= 1'b0;
      addr_reg <= '0;
      left_reg <= '0;
      hi_reg <= 1'b0;
      outst_reg <= '0;
      sent_reg <= '0;
      slots_reg <= '0;
      breq_n_reg <= 1'b1;
      strobe_n_reg <= 1'b1;
      oe_reg <= 1'b0;
      ad_reg <= '0;
      cbe_n_reg <= 4'hf;
      ready_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      busy_reg <= busy_next;
      split_reg <= split_next;
      addr_reg <= addr_next;
      left_reg <= left_next;
      hi_reg <= hi_next;
      outst_reg <= outst_next;
      sent_reg <= sent_next;
      slots_reg <= slots_next;
      breq_n_reg <= breq_n_next;
      strobe_n_reg <= strobe_n_next;
      oe_reg <= oe_next;
      ad_reg <= ad_next;
      cbe_n_reg <= cbe_n_next;
      ready_reg <= ready_next;
    end
  end

  assign LINK.bus_request_n = breq_n_reg;
  assign LINK.request_enqueue_strobe_n = strobe_n_reg;
  assign LINK.frame_n = 1'b1;
  assign LINK.addr_data_bus = ad_reg;
  assign LINK.command_byte_enable_n = cbe_n_reg;
  assign LINK.addr_data_oe = oe_reg;
  assign RD_READY_OUT = ready_reg;
  assign OUTSTANDING_OUT = outst_reg;
endmodule
`default_nettype wire

// *** rtl/pipe_bus_arbiter.sv ***
// Bridge end: grants the link and collects enqueued read requests
`timescale 1ns/10ps
`default_nettype none
module pipe_bus_arbiter (
  input wire logic CLK_SYS_IN,
  input wire logic NRST_IN,
  pipe_req_if.arbiter LINK,
  input wire logic GRANT_ALLOW_IN,
  output logic REQ_VALID_OUT,
  output logic [pipe_req_pkg::ADDR_W-1:0] REQ_ADDR_OUT,
  output logic [pipe_req_pkg::LEN_W-1:0] REQ_LEN_OUT,
  output logic [pipe_req_pkg::CMD_W-1:0] REQ_CMD_OUT,
  output logic REQ_LAST_OUT
);
  import pipe_req_pkg::*;

  typedef enum logic [1:0] {
    AS_IDLE = 2'b00,
    AS_GRANT = 2'b01,
    AS_HOLD = 2'b10
  } arb_state_t;

  arb_state_t state_reg, state_next;
  logic breq_s1_reg, breq_s2_reg;
  logic strb_s1_reg, strb_s2_reg;
  logic [ADDR_W-1:0] ad_s1_reg, ad_s2_reg;
  logic [CMD_W-1:0] cbe_s1_reg, cbe_s2_reg;
  logic gnt_n_reg, gnt_n_next;
  logic [STAT_W-1:0] stat_reg, stat_next;
  logic vld_reg, vld_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [LEN_W-1:0] len_reg, len_next;
  logic [CMD_W-1:0] cmd_reg, cmd_next;
  logic last_reg, last_next;

  // Collected fields pass two stages in step, so strobe and request stay aligned
  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      breq_s1_reg <= 1'b1;
      breq_s2_reg <= 1'b1;
      strb_s1_reg <= 1'b1;
      strb_s2_reg <= 1'b1;
      ad_s1_reg <= '0;
      ad_s2_reg <= '0;
      cbe_s1_reg <= 4'hf;
      cbe_s2_reg <= 4'hf;
    end
    else
    begin
      breq_s1_reg <= LINK.bus_request_n;
      breq_s2_reg <= breq_s1_reg;
      strb_s1_reg <= LINK.request_enqueue_strobe_n;
      strb_s2_reg <= strb_s1_reg;
      ad_s1_reg <= LINK.addr_data_bus;
      ad_s2_reg <= ad_s1_reg;
      cbe_s1_reg <= LINK.command_byte_enable_n;
      cbe_s2_reg <= cbe_s1_reg;
    end
  end

  always_comb
  begin
    state_next = state_reg;
    gnt_n_next = gnt_n_reg;
    stat_next = stat_reg;
    vld_next = 1'b0;
    addr_next = addr_reg;
    len_next = len_reg;
    cmd_next = cmd_reg;
    last_next = 1'b0;
    if (!strb_s2_reg)
    begin
      vld_next = 1'b1;
      addr_next = {ad_s2_reg[ADDR_MSB:ADDR_LSB], 3'h0};
      len_next = ad_s2_reg[LEN_MSB:LEN_LSB];
      cmd_next = ~cbe_s2_reg;
      last_next = breq_s2_reg;
    end
    case (state_reg)
      AS_IDLE:
      begin
        if (!LINK.bus_request_n && GRANT_ALLOW_IN)
        begin
          gnt_n_next = 1'b0;
          stat_next = STAT_START;
          state_next = AS_GRANT;
        end
      end
      AS_GRANT:
      begin
        // Grant withdrawn once the master shows it has begun
        if (!LINK.request_enqueue_strobe_n || !LINK.frame_n) // see R19
        begin
          gnt_n_next = 1'b1;
          stat_next = STAT_IDLE;
          state_next = AS_HOLD;
        end
      end
      AS_HOLD:
      begin
        if (LINK.request_enqueue_strobe_n && LINK.bus_request_n)
          state_next = AS_IDLE;
      end
      default:
        state_next = AS_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or negedge NRST_IN)
  begin
    if (!NRST_IN)
    begin
      state_reg <= AS_IDLE;
      gnt_n_reg <= 1'b1;
      stat_reg <= STAT_IDLE;
      vld_reg <= 1'b0;
      addr_reg <= '0;
      len_reg <= '0;
      cmd_reg <= '0;
      last_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      gnt_n_reg <= gnt_n_next;
      stat_reg <= stat_next;
      vld_reg <= vld_next;
      addr_reg <= addr_next;
      len_reg <= len_next;
      cmd_reg <= cmd_next;
      last_reg <= last_next;
    end
  end

  assign LINK.bus_grant_n = gnt_n_reg;
  assign LINK.grant_status_code = stat_reg;
  assign REQ_VALID_OUT = vld_reg;
  assign REQ_ADDR_OUT = addr_reg;
  assign REQ_LEN_OUT = len_reg;
  assign REQ_CMD_OUT = cmd_reg;
  assign REQ_LAST_OUT = last_reg;
endmodule
`default_nettype wire

// *** test/pipe_req_monitor.sv ***
// Concurrent checks on the link between requester and arbiter
`timescale 1ns/10ps
`default_nettype none
module pipe_req_monitor (
  input wire logic CLK_SYS_IN,
  input wire logic NRST_IN,
  input wire logic bus_request_n,
  input wire logic bus_grant_n,
  input wire logic [pipe_req_pkg::STAT_W-1:0] grant_status_code,
  input wire logic request_enqueue_strobe_n,
  input wire logic frame_n,
  input wire logic [pipe_req_pkg::ADDR_W-1:0] addr_data_bus,
  input wire logic [pipe_req_pkg::CMD_W-1:0] command_byte_enable_n,
  input wire logic addr_data_oe
);
  import pipe_req_pkg::*;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!NRST_IN);
  chk_cmd_legal: assert property (!request_enqueue_strobe_n |->
    (command_byte_enable_n == ~CMD_READ || command_byte_enable_n == ~CMD_READ_HI))
    else $error("illegal command while enqueuing");
  chk_drive_en: assert property (!request_enqueue_strobe_n |-> addr_data_oe)
    else $error("bus not driven during enqueue");
  chk_req_first: assert property ($rose(addr_data_oe) |-> $past(bus_request_n) == 1'b0)
    else $error("bus driven without prior request");
  chk_grant_start: assert property ($fell(bus_grant_n) |-> grant_status_code == STAT_START)
    else $error("grant without start status");
  // Grant is read directly on the shared clock, so two clocks at most
  chk_start_lat: assert property ($fell(bus_grant_n) && !bus_request_n |-> ##[1:2] !request_enqueue_strobe_n)
    else $error("enqueue late after start");
  chk_more_follow: assert property (!request_enqueue_strobe_n && !bus_request_n |=> !request_enqueue_strobe_n)
    else $error("strobe dropped while more promised");
  chk_strobe_rel: assert property (!request_enqueue_strobe_n && bus_request_n |=> request_enqueue_strobe_n)
    else $error("strobe held after last request");
  chk_last_mark: assert property ($rose(bus_request_n) |-> !request_enqueue_strobe_n)
    else $error("request released without last strobe");
  chk_grant_drop: assert property (($fell(request_enqueue_strobe_n) || $fell(frame_n)) && !bus_grant_n
    |-> ##1 bus_grant_n)
    else $error("grant not withdrawn");
endmodule
`default_nettype wire

// *** test/agp_pipelined_read_requester_test.sv ***
// Bench joining requester and arbiter over the link
`timescale 1ns/10ps
`default_nettype none
module agp_pipelined_read_requester_test;
  import pipe_req_pkg::*;
  logic clk, nrst, rd_valid, stall_near, reply_done, grant_allow, rd_ready, req_valid, req_last;
  logic [ADDR_W-1:0] rd_addr, req_addr;
  logic [BYTES_W-1:0] rd_bytes;
  logic [CNT_W-1:0] slots, outst_out;
  logic [LEN_W-1:0] req_len;
  logic [CMD_W-1:0] req_cmd;
  int mismatches, tests_run, outst;
  pipe_req_if link();
  pipe_read_requester u_pipe_read_requester (.CLK_SYS_IN(clk), .NRST_IN(nrst), .LINK(link.requester),
    .RD_VALID_IN(rd_valid), .RD_ADDR_IN(rd_addr), .RD_BYTES_IN(rd_bytes), .STALL_NEAR_IN(stall_near),
    .REPLY_DONE_IN(reply_done), .SLOTS_FREE_IN(slots), .RD_READY_OUT(rd_ready), .OUTSTANDING_OUT(outst_out));
  pipe_bus_arbiter u_pipe_bus_arbiter (.CLK_SYS_IN(clk), .NRST_IN(nrst), .LINK(link.arbiter),
    .GRANT_ALLOW_IN(grant_allow), .REQ_VALID_OUT(req_valid), .REQ_ADDR_OUT(req_addr), .REQ_LEN_OUT(req_len),
    .REQ_CMD_OUT(req_cmd), .REQ_LAST_OUT(req_last));
  pipe_req_monitor u_pipe_req_monitor (.CLK_SYS_IN(clk), .NRST_IN(nrst), .bus_request_n(link.bus_request_n),
    .bus_grant_n(link.bus_grant_n), .grant_status_code(link.grant_status_code),
    .request_enqueue_strobe_n(link.request_enqueue_strobe_n), .frame_n(link.frame_n),
    .addr_data_bus(link.addr_data_bus), .command_byte_enable_n(link.command_byte_enable_n),
    .addr_data_oe(link.addr_data_oe));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    check_val({31'h0, got}, {31'h0, exp});
  endtask

  task automatic timed_out();
    mismatches++;
    end_sim();
  endtask

  task automatic free_one();
    reply_done = 1'b1;
    @(negedge clk);
    reply_done = 1'b0;
    outst--;
    @(negedge clk);
    check_val(32'(outst_out), 32'(outst));
  endtask

  task automatic get_req(input logic [31:0] a, input logic [2:0] len, input logic [3:0] cmd, input logic last);
    int i;
    for (i = 0; i < 60 && req_valid !== 1'b1; i++)
      @(negedge clk);
    if (req_valid !== 1'b1)
      timed_out();
    check_val(req_addr, a);
    check_val(32'(req_len), 32'(len));
    check_val(32'(req_cmd), 32'(cmd));
    check_flag(req_last, last);
    @(negedge clk);
  endtask

  // Pieces expected per job; an operation ends when slots or queue run out
  task automatic do_job(input logic [31:0] a, input logic [11:0] b, input logic hi, input logic hold);
    int i, k, n, room;
    logic [2:0] len;
    n = (b > LIMIT_BYTES_V) ? int'(b / CHUNK_BYTES_V) : 1;
    len = (b > LIMIT_BYTES_V) ? LEN_CHUNK : 3'((b + 12'h007) / QWORD_BYTES_V - 12'h001);
    grant_allow = !hold;
    rd_addr = a;
    rd_bytes = b;
    stall_near = hi;
    rd_valid = 1'b1;
    for (i = 0; i < 20 && rd_ready !== 1'b1; i++)
      @(negedge clk);
    if (rd_ready !== 1'b1)
      timed_out();
    rd_valid = 1'b0;
    if (hold)
    begin
      repeat (10) @(negedge clk);
      check_flag(link.bus_request_n, 1'b0);
      check_flag(req_valid, 1'b0);
      grant_allow = 1'b1;
    end
    room = 0;
    for (k = 0; k < n; k++)
    begin
      if (room == 0)
      begin
        if (outst == QUEUE_DEPTH)
          free_one();
        room = (int'(slots) < QUEUE_DEPTH - outst) ? int'(slots) : QUEUE_DEPTH - outst;
      end
      room--;
      get_req(a + 32'(32 * k), len, hi ? CMD_READ_HI : CMD_READ, room == 0 || k == n - 1);
      outst++;
    end
    repeat (3) @(negedge clk);
    check_val(32'(outst_out), 32'(outst));
  endtask

  task automatic drain();
    while (outst > 0)
      free_one();
  endtask

  initial
  begin
    nrst = 1'b0;
    rd_valid = 1'b0;
    rd_addr = '0;
    rd_bytes = '0;
    stall_near = 1'b0;
    reply_done = 1'b0;
    grant_allow = 1'b1;
    slots = 3'h4;
    mismatches = 0;
    tests_run = 0;
    outst = 0;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    check_flag(link.bus_request_n, 1'b1);
    check_val(32'(outst_out), 32'h0);
    do_job(32'h0001_0000, 12'h008, 1'b0, 1'b0);
    do_job(32'h0002_0040, 12'h014, 1'b1, 1'b0);
    do_job(32'h0003_0080, 12'h040, 1'b0, 1'b0);
    drain();
    do_job(32'h0004_0000, 12'h060, 1'b0, 1'b0);
    drain();
    slots = 3'h2;
    do_job(32'h0005_0000, 12'h080, 1'b1, 1'b0);
    drain();
    slots = 3'h4;
    do_job(32'h0006_0000, 12'h100, 1'b0, 1'b0);
    drain();
    do_job(32'h0007_0100, 12'h018, 1'b1, 1'b1);
    drain();
    end_sim();
  end
endmodule
`default_nettype wire
